// File: ascl_far_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Pins and modulator seen from outside the block
// ----------------------------------------------------------------
module ascl_far_model (
  input wire logic clk,
  input wire logic [3:0] pin_set,
  input wire logic pwm_set,
  output logic [3:0] pin_out,
  output logic pwm_out
);
  // Start quiet
  initial begin
    pin_out = 4'h0;
    pwm_out = 1'b0;
  end
  // Pins move off the clock grid
  always @(pin_set) begin
    pin_out <= #13 pin_set;
  end
  // Modulator output lives in the clock domain
  always @(posedge clk) begin
    pwm_out <= pwm_set;
  end
endmodule

// File: ascl_pin_sync.sv
`timescale 1ns/1ps
module ascl_pin_sync #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  // ----------------------------------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------------------------------
  logic [W-1:0] meta_q; // First stage, read only by second
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q; // Second stage
  logic [W-1:0] sync_d;

  // Next values
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  // Registers, cleared by synchronous reset
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

// File: ascl_pkg.sv
// Notes on behaviour
// - DAC A switch closes on bit, pin or modulator
// - DAC B switch closes on bit, pin or modulator
// - Pin level converted through its polarity first
// - Pins not assigned to a switch feed zero
// - Unrouted modulator feeds zero into switch
// - Both buffer bits reset to zero
// - Throw one drive is OR of three sources
// - Throw one mode zero: contacts follow drive together
// - Throw one mode one: contacts toggle opposite
// - Throw one modulator share from one select bit
// - Throw two drive is OR of three sources
// - Throw two mode zero: contacts follow drive together
// - Throw two mode one: contacts toggle opposite
// - Throw two modulator share from one select bit
// - Throw two control field resets to zero
// - Pins sharing one function are ORed
// - Control register bit order fixed, two unused
package ascl_pkg;

  // ----------------------------------------------------------------
  // Bus geometry and register map
  // ----------------------------------------------------------------
  localparam int ASCL_ADDR_W = 8;
  localparam logic [7:0] ASCL_OFF_SWITCH_CTRL = 8'h00;
  localparam logic [7:0] ASCL_OFF_PIN_CTRL = 8'h04;
  localparam logic [7:0] ASCL_OFF_MOD_SEL = 8'h08;
  localparam logic [7:0] ASCL_OFF_SW_STATE = 8'h0C;

  // Register index after decode
  localparam logic [2:0] ASCL_IDX_SWITCH_CTRL = 3'h0;
  localparam logic [2:0] ASCL_IDX_PIN_CTRL = 3'h1;
  localparam logic [2:0] ASCL_IDX_MOD_SEL = 3'h2;
  localparam logic [2:0] ASCL_IDX_SW_STATE = 3'h3;
  localparam logic [2:0] ASCL_IDX_NONE = 3'h4;

  // Bus responses
  localparam logic [1:0] ASCL_RESP_OKAY = 2'h0;
  localparam logic [1:0] ASCL_RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // User pin control layout
  // ----------------------------------------------------------------
  localparam int ASCL_NUM_PINS = 4;
  localparam int ASCL_PIN_LEVEL_LSB = 0;
  localparam int ASCL_PIN_FUNC_LSB = 8;
  localparam int ASCL_PIN_FUNC_STRIDE = 4;
  localparam int ASCL_PIN_FUNC_W = 3;
  localparam logic [31:0] ASCL_PIN_CTRL_MASK = 32'h0077770F;

  // Reset values
  localparam logic [7:0] ASCL_RST_SWITCH_CTRL = 8'h00;
  localparam logic [31:0] ASCL_RST_PIN_CTRL = 32'h00000000;
  localparam logic [5:0] ASCL_RST_MOD_SEL = 6'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Pin function codes
  typedef enum logic [2:0] {
    ASCL_FN_NONE = 3'h0,
    ASCL_FN_DAC_A = 3'h1,
    ASCL_FN_DAC_B = 3'h2,
    ASCL_FN_THROW1 = 3'h3,
    ASCL_FN_THROW2 = 3'h4
  } ascl_fn_t;

  // Switch control register, MSB first
  typedef struct packed {
    logic dac_a_buffer_switch_bit;
    logic dac_b_buffer_switch_bit;
    logic throw1_toggle_mode_bit;
    logic throw1_drive_bit;
    logic throw2_toggle_mode_bit;
    logic throw2_drive_bit;
    logic [1:0] unused;
  } ascl_switch_control_register_t;

  // Modulator routing selects, MSB first
  typedef struct packed {
    logic throw2_mod_select;
    logic throw1_mod_select;
    logic dac_b_mod_low_select;
    logic dac_b_mod_high_select;
    logic dac_a_mod_low_select;
    logic dac_a_mod_high_select;
  } ascl_mod_sel_t;

  // Switch element drives, 1 = closed
  typedef struct packed {
    logic dac_a_close;
    logic dac_b_close;
    logic sw1_normally_open_contact;
    logic sw1_normally_closed_contact;
    logic sw2_normally_open_contact;
    logic sw2_normally_closed_contact;
  } ascl_drive_t;

  // ----------------------------------------------------------------
  // Shared functions
  // ----------------------------------------------------------------
  // Byte address to register index
  function automatic logic [2:0] ascl_decode(input logic [ASCL_ADDR_W-1:0] addr);
    logic [2:0] idx;
    idx = ASCL_IDX_NONE;
    unique case (addr)
      ASCL_OFF_SWITCH_CTRL: idx = ASCL_IDX_SWITCH_CTRL;
      ASCL_OFF_PIN_CTRL: idx = ASCL_IDX_PIN_CTRL;
      ASCL_OFF_MOD_SEL: idx = ASCL_IDX_MOD_SEL;
      ASCL_OFF_SW_STATE: idx = ASCL_IDX_SW_STATE;
      default: idx = ASCL_IDX_NONE;
    endcase
    return idx;
  endfunction

  // Byte-lane merge of write data into old value
  function automatic logic [31:0] ascl_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

endpackage

// File: ascl_switch_mix.sv
`timescale 1ns/1ps
module ascl_switch_mix
  import ascl_pkg::*;
(
  input wire ascl_switch_control_register_t ctrl,
  input wire ascl_mod_sel_t mod_sel,
  input wire logic [31:0] pin_ctrl,
  input wire logic [ASCL_NUM_PINS-1:0] pin_level,
  input wire logic pwm,
  output ascl_drive_t drive
);

  // ----------------------------------------------------------------
  // Pin vote: OR of asserted pins assigned to one function
  // ----------------------------------------------------------------
  function automatic logic pin_vote(input logic [ASCL_NUM_PINS-1:0] asserted,
                                    input logic [31:0] cfg,
                                    input ascl_fn_t fn);
    logic hit;
    hit = 1'b0;
    for (int p = 0; p < ASCL_NUM_PINS; p++) begin
      // Pins set to other functions add nothing
      if (cfg[ASCL_PIN_FUNC_LSB + ASCL_PIN_FUNC_STRIDE*p +: ASCL_PIN_FUNC_W] == fn) begin
        hit = hit | asserted[p];
      end
    end
    return hit;
  endfunction

  // ----------------------------------------------------------------
  // Combinational mixing of the three sources
  // ----------------------------------------------------------------
  logic [ASCL_NUM_PINS-1:0] asserted; // Pins after polarity
  logic mod_a; // Modulator share per switch
  logic mod_b;
  logic mod_t1;
  logic mod_t2;
  logic drv_t1; // Throw drives
  logic drv_t2;

  always_comb begin
    // Polarity: level bit 1 means active high
    asserted = ~(pin_level ^ pin_ctrl[ASCL_PIN_LEVEL_LSB +: ASCL_NUM_PINS]);
    // Buffer switches: high select passes on-phase, low select off-phase
    mod_a = (mod_sel.dac_a_mod_high_select & pwm)
          | (mod_sel.dac_a_mod_low_select & ~pwm);
    mod_b = (mod_sel.dac_b_mod_high_select & pwm)
          | (mod_sel.dac_b_mod_low_select & ~pwm);
    mod_t1 = mod_sel.throw1_mod_select & pwm;
    mod_t2 = mod_sel.throw2_mod_select & pwm;
    drive.dac_a_close = ctrl.dac_a_buffer_switch_bit | pin_vote(asserted, pin_ctrl, ASCL_FN_DAC_A)
                      | mod_a;
    drive.dac_b_close = ctrl.dac_b_buffer_switch_bit | pin_vote(asserted, pin_ctrl, ASCL_FN_DAC_B)
                      | mod_b;
    drv_t1 = ctrl.throw1_drive_bit | pin_vote(asserted, pin_ctrl, ASCL_FN_THROW1) | mod_t1;
    drv_t2 = ctrl.throw2_drive_bit | pin_vote(asserted, pin_ctrl, ASCL_FN_THROW2) | mod_t2;
    // Open contact follows drive in both modes
    drive.sw1_normally_open_contact = drv_t1;
    // Closed contact follows in mode 0, inverts in mode 1
    drive.sw1_normally_closed_contact = drv_t1 ^ ctrl.throw1_toggle_mode_bit;
    drive.sw2_normally_open_contact = drv_t2;
    drive.sw2_normally_closed_contact = drv_t2 ^ ctrl.throw2_toggle_mode_bit;
  end

endmodule

// File: ascl_top.sv
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module ascl_top
  import ascl_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST,
  // AXI4-Lite write address
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [ASCL_ADDR_W-1:0] AWADDR,
  input wire logic [2:0] AWPROT,
  // AXI4-Lite write data
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  // AXI4-Lite write response
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  // AXI4-Lite read address
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [ASCL_ADDR_W-1:0] ARADDR,
  input wire logic [2:0] ARPROT,
  // AXI4-Lite read data
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  // User pins and modulator
  input wire logic [ASCL_NUM_PINS-1:0] USER_PROGRAMMABLE_PIN,
  input wire logic PWM_LEVEL,
  // Switch element drives, 1 = closed
  output logic DAC_A_BUFFER_SWITCH,
  output logic DAC_B_BUFFER_SWITCH,
  output logic SW1_NORMALLY_OPEN_CONTACT,
  output logic SW1_NORMALLY_CLOSED_CONTACT,
  output logic SW2_NORMALLY_OPEN_CONTACT,
  output logic SW2_NORMALLY_CLOSED_CONTACT
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  // Write channel state
  logic aw_rdy_q; // Address ready
  logic aw_rdy_d;
  logic aw_got_q; // Address captured
  logic aw_got_d;
  logic [ASCL_ADDR_W-1:0] aw_addr_q; // Captured address
  logic [ASCL_ADDR_W-1:0] aw_addr_d;
  logic w_rdy_q; // Data ready
  logic w_rdy_d;
  logic w_got_q; // Data captured
  logic w_got_d;
  logic [31:0] w_data_q; // Captured data
  logic [31:0] w_data_d;
  logic [3:0] w_strb_q; // Captured strobes
  logic [3:0] w_strb_d;
  logic bvalid_q; // Response pending
  logic bvalid_d;
  logic [1:0] bresp_q; // Response code
  logic [1:0] bresp_d;

  // Read channel state
  logic ar_rdy_q; // Read address ready
  logic ar_rdy_d;
  logic rvalid_q; // Read data pending
  logic rvalid_d;
  logic [31:0] rdata_q; // Read data
  logic [31:0] rdata_d;
  logic [1:0] rresp_q; // Read response
  logic [1:0] rresp_d;

  // Software registers
  ascl_switch_control_register_t ctrl_q; // Switch control register
  ascl_switch_control_register_t ctrl_d;
  logic [31:0] pin_ctrl_q; // User pin control register
  logic [31:0] pin_ctrl_d;
  ascl_mod_sel_t mod_sel_q; // Modulator routing
  ascl_mod_sel_t mod_sel_d;

  // Switch outputs
  ascl_drive_t drive_q; // Registered drives
  ascl_drive_t drive_d;

  // Helpers
  logic [2:0] wr_idx; // Decoded write target
  logic [2:0] rd_idx; // Decoded read target
  logic [31:0] merged; // Strobe-merged write value
  logic [ASCL_NUM_PINS-1:0] pin_sync; // Pins after synchroniser

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  ascl_pin_sync #(
    .W(ASCL_NUM_PINS)
  ) u_pin_sync (
    .clk(MCLK),
    .rst(RST),
    .async_in(USER_PROGRAMMABLE_PIN),
    .sync_out(pin_sync)
  );

  // ----------------------------------------------------------------
  // Switch mixing
  // ----------------------------------------------------------------
  // Modulator comes from logic on this clock and needs no sync
  ascl_switch_mix u_mix (
    .ctrl(ctrl_q),
    .mod_sel(mod_sel_q),
    .pin_ctrl(pin_ctrl_q),
    .pin_level(pin_sync),
    .pwm(PWM_LEVEL),
    .drive(drive_d)
  );

  // ----------------------------------------------------------------
  // Write channel and register update
  // ----------------------------------------------------------------
  // Address and data taken in either order, then one write cycle
  always_comb begin
    aw_got_d = aw_got_q;
    aw_addr_d = aw_addr_q;
    w_got_d = w_got_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    ctrl_d = ctrl_q;
    pin_ctrl_d = pin_ctrl_q;
    mod_sel_d = mod_sel_q;
    wr_idx = ascl_decode(aw_addr_q);
    merged = '0;
    // Response retires on handshake
    if (bvalid_q && BREADY) begin
      bvalid_d = 1'b0;
    end
    // Capture address
    if (AWVALID && aw_rdy_q) begin
      aw_got_d = 1'b1;
      aw_addr_d = AWADDR;
    end
    // Capture data
    if (WVALID && w_rdy_q) begin
      w_got_d = 1'b1;
      w_data_d = WDATA;
      w_strb_d = WSTRB;
    end
    // Both halves held: perform the write
    if (aw_got_q && w_got_q && !bvalid_q) begin
      aw_got_d = 1'b0;
      w_got_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = ASCL_RESP_OKAY;
      unique case (wr_idx)
        ASCL_IDX_SWITCH_CTRL: begin
          merged = ascl_merge({24'h000000, ctrl_q}, w_data_q, w_strb_q);
          // Unused low bits stay zero
          ctrl_d = ascl_switch_control_register_t'({merged[7:2], 2'h0});
        end
        ASCL_IDX_PIN_CTRL: begin
          merged = ascl_merge(pin_ctrl_q, w_data_q, w_strb_q);
          pin_ctrl_d = merged & ASCL_PIN_CTRL_MASK;
        end
        ASCL_IDX_MOD_SEL: begin
          merged = ascl_merge({26'h0000000, mod_sel_q}, w_data_q, w_strb_q);
          mod_sel_d = ascl_mod_sel_t'(merged[5:0]);
        end
        ASCL_IDX_SW_STATE: begin
          // Read-only: write ignored
          bresp_d = ASCL_RESP_OKAY;
        end
        default: begin
          // Unmapped address
          bresp_d = ASCL_RESP_SLVERR;
        end
      endcase
    end
    // Ready only while the slot is free and no response waits
    aw_rdy_d = !aw_got_d && !bvalid_d;
    w_rdy_d = !w_got_d && !bvalid_d;
  end

  // Write channel registers
  always_ff @(posedge MCLK) begin
    if (RST) begin
      aw_rdy_q <= 1'b0;
      aw_got_q <= 1'b0;
      aw_addr_q <= '0;
      w_rdy_q <= 1'b0;
      w_got_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= ASCL_RESP_OKAY;
      ctrl_q <= ascl_switch_control_register_t'(ASCL_RST_SWITCH_CTRL);
      pin_ctrl_q <= ASCL_RST_PIN_CTRL;
      mod_sel_q <= ascl_mod_sel_t'(ASCL_RST_MOD_SEL);
    end else begin
      aw_rdy_q <= aw_rdy_d;
      aw_got_q <= aw_got_d;
      aw_addr_q <= aw_addr_d;
      w_rdy_q <= w_rdy_d;
      w_got_q <= w_got_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      ctrl_q <= ctrl_d;
      pin_ctrl_q <= pin_ctrl_d;
      mod_sel_q <= mod_sel_d;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  // One read in flight; data appear the cycle after the address
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    rd_idx = ascl_decode(ARADDR);
    // Data retire on handshake
    if (rvalid_q && RREADY) begin
      rvalid_d = 1'b0;
    end
    // Take a new address
    if (ARVALID && ar_rdy_q) begin
      rvalid_d = 1'b1;
      rresp_d = ASCL_RESP_OKAY;
      unique case (rd_idx)
        ASCL_IDX_SWITCH_CTRL: rdata_d = {24'h000000, ctrl_q};
        ASCL_IDX_PIN_CTRL: rdata_d = pin_ctrl_q;
        ASCL_IDX_MOD_SEL: rdata_d = {26'h0000000, mod_sel_q};
        ASCL_IDX_SW_STATE: rdata_d = {26'h0000000, drive_q};
        default: begin
          // Unmapped address reads zero with error
          rdata_d = 32'h00000000;
          rresp_d = ASCL_RESP_SLVERR;
        end
      endcase
    end
    // Ready once data retire
    ar_rdy_d = !rvalid_d;
  end

  // Read channel registers
  always_ff @(posedge MCLK) begin
    if (RST) begin
      // Idle after reset
      ar_rdy_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= ASCL_RESP_OKAY;
    end else begin
      // Next read state
      ar_rdy_q <= ar_rdy_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // ----------------------------------------------------------------
  // Switch drive register
  // ----------------------------------------------------------------
  // Output flop keeps pins glitch-free; the mix ahead is combinational
  always_ff @(posedge MCLK) begin
    if (RST) begin
      // All open
      drive_q <= '0;
    end else begin
      // Follow mix
      drive_q <= drive_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Bus outputs
  assign AWREADY = aw_rdy_q;
  assign WREADY = w_rdy_q;
  assign BVALID = bvalid_q;
  assign BRESP = bresp_q;
  assign ARREADY = ar_rdy_q;
  assign RVALID = rvalid_q;
  assign RDATA = rdata_q;
  assign RRESP = rresp_q;
  // Switch outputs
  assign DAC_A_BUFFER_SWITCH = drive_q.dac_a_close;
  assign DAC_B_BUFFER_SWITCH = drive_q.dac_b_close;
  assign SW1_NORMALLY_OPEN_CONTACT = drive_q.sw1_normally_open_contact;
  assign SW1_NORMALLY_CLOSED_CONTACT = drive_q.sw1_normally_closed_contact;
  assign SW2_NORMALLY_OPEN_CONTACT = drive_q.sw2_normally_open_contact;
  assign SW2_NORMALLY_CLOSED_CONTACT = drive_q.sw2_normally_closed_contact;

endmodule

// File: ascl_top_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checker for the switch block
// ----------------------------------------------------------------
module ascl_top_monitor
  import ascl_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic [ASCL_ADDR_W-1:0] AWADDR,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic [1:0] BRESP,
  input wire logic DAC_A_BUFFER_SWITCH,
  input wire logic DAC_B_BUFFER_SWITCH,
  input wire logic SW1_NORMALLY_OPEN_CONTACT,
  input wire logic SW1_NORMALLY_CLOSED_CONTACT,
  input wire logic SW2_NORMALLY_OPEN_CONTACT,
  input wire logic SW2_NORMALLY_CLOSED_CONTACT
);
  logic [7:0] aw_q, aw_d; // Captured write address
  logic [7:0] wd_q, wd_d; // Captured low data byte
  logic ws_q, ws_d; // Low byte lane enabled
  logic [7:0] sh_q, sh_d; // Shadow of the switch control byte
  // Track accepted writes to the control word
  always_comb begin
    aw_d = aw_q;
    wd_d = wd_q;
    ws_d = ws_q;
    sh_d = sh_q;
    if (AWVALID && AWREADY) aw_d = AWADDR;
    if (WVALID && WREADY) wd_d = WDATA[7:0];
    if (WVALID && WREADY) ws_d = WSTRB[0];
    if (BVALID && BREADY && aw_q == ASCL_OFF_SWITCH_CTRL && ws_q && BRESP == ASCL_RESP_OKAY) begin
      sh_d = wd_q;
    end
    if (RST) begin
      aw_d = 8'h00;
      wd_d = 8'h00;
      ws_d = 1'b0;
      sh_d = 8'h00;
    end
  end
  // Register the shadow state
  always_ff @(posedge MCLK) begin
    aw_q <= aw_d;
    wd_q <= wd_d;
    ws_q <= ws_d;
    sh_q <= sh_d;
  end
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  sequence s_release;
    $fell(RST);
  endsequence
  sequence s_all_open;
    !(DAC_A_BUFFER_SWITCH || DAC_B_BUFFER_SWITCH || SW1_NORMALLY_OPEN_CONTACT ||
      SW1_NORMALLY_CLOSED_CONTACT || SW2_NORMALLY_OPEN_CONTACT || SW2_NORMALLY_CLOSED_CONTACT);
  endsequence
  AST_RST_OPEN: assert property (s_release |-> s_all_open)
    else $error("switches not open after reset");
  AST_A_BIT: assert property (!BVALID && sh_q[7] |-> DAC_A_BUFFER_SWITCH)
    else $error("dac A switch open with its bit set");
  AST_B_BIT: assert property (!BVALID && sh_q[6] |-> DAC_B_BUFFER_SWITCH)
    else $error("dac B switch open with its bit set");
  AST_T1_DRV: assert property (!BVALID && sh_q[4] |-> SW1_NORMALLY_OPEN_CONTACT)
    else $error("throw one not driven by its bit");
  AST_T2_DRV: assert property (!BVALID && sh_q[2] |-> SW2_NORMALLY_OPEN_CONTACT)
    else $error("throw two not driven by its bit");
  AST_T1_SAME: assert property (!BVALID && !sh_q[5] |->
    SW1_NORMALLY_OPEN_CONTACT == SW1_NORMALLY_CLOSED_CONTACT)
    else $error("throw one contacts differ in mode zero");
  AST_T1_TOG: assert property (!BVALID && sh_q[5] |->
    SW1_NORMALLY_OPEN_CONTACT != SW1_NORMALLY_CLOSED_CONTACT)
    else $error("throw one contacts equal in toggle mode");
  AST_T2_SAME: assert property (!BVALID && !sh_q[3] |->
    SW2_NORMALLY_OPEN_CONTACT == SW2_NORMALLY_CLOSED_CONTACT)
    else $error("throw two contacts differ in mode zero");
  AST_T2_TOG: assert property (!BVALID && sh_q[3] |->
    SW2_NORMALLY_OPEN_CONTACT != SW2_NORMALLY_CLOSED_CONTACT)
    else $error("throw two contacts equal in toggle mode");
endmodule
bind ascl_top ascl_top_monitor u_mon (.MCLK(MCLK), .RST(RST), .AWVALID(AWVALID), .AWREADY(AWREADY),
  .AWADDR(AWADDR), .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB), .BVALID(BVALID),
  .BREADY(BREADY), .BRESP(BRESP), .DAC_A_BUFFER_SWITCH(DAC_A_BUFFER_SWITCH),
  .DAC_B_BUFFER_SWITCH(DAC_B_BUFFER_SWITCH), .SW1_NORMALLY_OPEN_CONTACT(SW1_NORMALLY_OPEN_CONTACT),
  .SW1_NORMALLY_CLOSED_CONTACT(SW1_NORMALLY_CLOSED_CONTACT),
  .SW2_NORMALLY_OPEN_CONTACT(SW2_NORMALLY_OPEN_CONTACT),
  .SW2_NORMALLY_CLOSED_CONTACT(SW2_NORMALLY_CLOSED_CONTACT));

// File: ascl_top_tb.sv
`timescale 1ns/1ps
module ascl_top_tb
  import ascl_pkg::*;
();
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic MCLK = 1'b0, RST = 1'b1, pwm_set = 1'b0, pw;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00, sw;
  logic [31:0] WDATA = 32'h00000000, pc, r;
  logic [3:0] WSTRB = 4'h0, pin_set = 4'h0, pins;
  logic [5:0] md, drv; // Switch outputs, dac A first
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, PWM_LEVEL;
  logic [1:0] BRESP, RRESP;
  logic [31:0] RDATA;
  logic [3:0] USER_PROGRAMMABLE_PIN;
  logic [1:0] qb[$]; // Expected write responses
  logic [33:0] qr[$]; // Expected read response and data
  int n_mismatch = 0, samples_checked = 0;
  integer seed = 32'hA29DA1D1;
  always #25 MCLK = ~MCLK;
  ascl_top uut (.MCLK(MCLK), .RST(RST), .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR),
    .AWPROT(3'h0), .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .ARADDR(ARADDR), .ARPROT(3'h0), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA),
    .RRESP(RRESP), .USER_PROGRAMMABLE_PIN(USER_PROGRAMMABLE_PIN), .PWM_LEVEL(PWM_LEVEL),
    .DAC_A_BUFFER_SWITCH(drv[5]), .DAC_B_BUFFER_SWITCH(drv[4]),
    .SW1_NORMALLY_OPEN_CONTACT(drv[3]), .SW1_NORMALLY_CLOSED_CONTACT(drv[2]),
    .SW2_NORMALLY_OPEN_CONTACT(drv[1]), .SW2_NORMALLY_CLOSED_CONTACT(drv[0]));
  ascl_far_model u_far (.clk(MCLK), .pin_set(pin_set), .pwm_set(pwm_set),
    .pin_out(USER_PROGRAMMABLE_PIN), .pwm_out(PWM_LEVEL));
  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  // Expected switch state word from control, pins and modulator
  function automatic logic [31:0] exp_state(input logic [7:0] s, input logic [31:0] c,
                                            input logic [5:0] m, input logic [3:0] p,
                                            input logic w);
    logic [4:0] u;
    logic a, b, d1, d2;
    logic [2:0] f;
    u = 5'h00;
    for (int n = 0; n < 4; n++) begin
      f = c[8+4*n +: 3];
      if (f >= 3'h1 && f <= 3'h4) u[f] = u[f] | (c[n] ? p[n] : ~p[n]);
    end
    a = s[7] | u[1] | (m[0] & w) | (m[1] & ~w);
    b = s[6] | u[2] | (m[2] & w) | (m[3] & ~w);
    d1 = s[4] | u[3] | (m[4] & w);
    d2 = s[2] | u[4] | (m[5] & w);
    return {26'h0000000, a, b, d1, d1 ^ s[5], d2, d2 ^ s[3]};
  endfunction
  task automatic cmp_wr(input logic [1:0] e, input logic [1:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cmp_rd(input logic [33:0] e, input logic [33:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // Master write: address and data together, response last
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] e);
    @(posedge MCLK);
    qb.push_back(e);
    AWADDR <= a;
    WDATA <= d;
    WSTRB <= s;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge MCLK);
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
    end while (!(BVALID && BREADY));
    BREADY <= 1'b0;
  endtask
  // Master read with expected data and response
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge MCLK);
    qr.push_back({e, d});
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge MCLK);
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
    end while (!(RVALID && RREADY));
    RREADY <= 1'b0;
  endtask
  // Responses are compared against the oldest note
  always @(posedge MCLK) begin
    if (BVALID && BREADY) cmp_wr(qb.pop_front(), BRESP);
    if (RVALID && RREADY) cmp_rd(qr.pop_front(), {RRESP, RDATA});
  end
  task automatic finish_test();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge MCLK);
    RST <= 1'b0;
    repeat (2) @(posedge MCLK);
    axi_rd(ASCL_OFF_SWITCH_CTRL, 32'h00000000, ASCL_RESP_OKAY);
    axi_rd(ASCL_OFF_PIN_CTRL, 32'h00000000, ASCL_RESP_OKAY);
    axi_rd(ASCL_OFF_MOD_SEL, 32'h00000000, ASCL_RESP_OKAY);
    axi_rd(8'h10, 32'h00000000, ASCL_RESP_SLVERR);
    axi_wr(8'h10, 32'hFFFFFFFF, 4'hF, ASCL_RESP_SLVERR);
    axi_rd(ASCL_OFF_SW_STATE, 32'h00000000, ASCL_RESP_OKAY);
    axi_wr(ASCL_OFF_SWITCH_CTRL, 32'hFFFFFFFF, 4'hF, ASCL_RESP_OKAY);
    axi_rd(ASCL_OFF_SWITCH_CTRL, 32'h000000FC, ASCL_RESP_OKAY);
    axi_wr(ASCL_OFF_SWITCH_CTRL, 32'h00000000, 4'h0, ASCL_RESP_OKAY);
    axi_rd(ASCL_OFF_SW_STATE, 32'h0000003A, ASCL_RESP_OKAY);
    // Random routing, polarity, pins and modulator phase
    for (int i = 0; i < 48; i++) begin
      r = $random(seed);
      sw = r[7:0];
      md = r[13:8];
      pw = r[14];
      pins = r[19:16];
      pc = $random(seed);
      pin_set <= pins;
      pwm_set <= pw;
      axi_wr(ASCL_OFF_SWITCH_CTRL, {24'h000000, sw}, 4'h1, ASCL_RESP_OKAY);
      axi_wr(ASCL_OFF_PIN_CTRL, pc, 4'hF, ASCL_RESP_OKAY);
      axi_wr(ASCL_OFF_MOD_SEL, {26'h0000000, md}, 4'hF, ASCL_RESP_OKAY);
      axi_wr(ASCL_OFF_SW_STATE, r, 4'hF, ASCL_RESP_OKAY);
      repeat (4) @(posedge MCLK);
      axi_rd(ASCL_OFF_SWITCH_CTRL, {24'h000000, sw[7:2], 2'b00}, ASCL_RESP_OKAY);
      axi_rd(ASCL_OFF_PIN_CTRL, pc & ASCL_PIN_CTRL_MASK, ASCL_RESP_OKAY);
      axi_rd(ASCL_OFF_SW_STATE, exp_state(sw, pc, md, pins, pw), ASCL_RESP_OKAY);
      cmp_rd({2'h0, exp_state(sw, pc, md, pins, pw)}, {28'h0000000, drv});
    end
    finish_test();
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge MCLK);
    n_mismatch++;
    finish_test();
  end
endmodule
